// >>> hw/bstp_defines.vh
// constants for the boundary-scan test port: instruction codes, id fields, timing
// assumes it is included by bare name from the design files
// How it works
// - 4-bit instruction; 0000 boundary chain, cells drive outputs
// - 1111 selects one-bit passthrough register
// - 0010 loads and shifts 32-bit identification value
// - 0100 floats all outputs, passthrough in path
// - 0011 cells drive outputs, passthrough in path
// - 0001 boundary chain samples pins or preloads
// - id: revision, part, vendor fields, bit0 one
`ifndef BSTP_DEFINES_VH
`define BSTP_DEFINES_VH
`define BSTP_IR_W        4
`define BSTP_OP_EXTEST   4'h0
`define BSTP_OP_SAMPLE   4'h1
`define BSTP_OP_IDCODE   4'h2
`define BSTP_OP_CLAMP    4'h3
`define BSTP_OP_HIGHZ    4'h4
`define BSTP_OP_BYPASS   4'hf
`define BSTP_ID_W        32
`define BSTP_REV_HI      31
`define BSTP_REV_LO      28
`define BSTP_PART_HI     27
`define BSTP_PART_LO     12
`define BSTP_VEND_HI     11
`define BSTP_VEND_LO     1
`define BSTP_TCK_NS      100
`define BSTP_CLK_NS      100
`endif

// >>> hw/bstp_chain.v
// boundary cell chain: capture/shift stage plus update stage per cell
// assumes shift/capture/update strobes are one-cycle pulses on CLK_I
`timescale 1ns/100ps
`default_nettype none
module bstp_chain #(
	parameter N = 8
) (
	input  wire         clk_i,
	input  wire         rst_i,
	input  wire         capture_i,
	input  wire         shift_i,
	input  wire         update_i,
	input  wire         si_i,
	input  wire [N-1:0] pins_i,
	output wire         so_o,
	output reg  [N-1:0] cells_o
);
	reg [N-1:0] stage;
	// shift stage: pins captured, serial data moves toward so_o (bit 0)
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage <= {N{1'b0}};
		end else if (capture_i) begin
			stage <= pins_i;
		end else if (shift_i) begin
			stage <= {si_i, stage[N-1:1]};
		end
	end
	// update stage holds preloaded values so outputs stay still while shifting
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cells_o <= {N{1'b0}};
		end else if (update_i) begin
			cells_o <= stage;
		end
	end
	assign so_o = stage[0];
endmodule
`default_nettype wire

// >>> hw/bstp_top.v
// boundary-scan test port top: tap controller, instruction, id, bypass, pin muxing
// assumes TCK/TMS/TDI/TRST_N arrive asynchronously; CLK_I much faster than TCK
`timescale 1ns/100ps
`default_nettype none
`include "bstp_defines.vh"
module bstp_top #(
	parameter       BSC_N = 8,
	parameter [3:0] REV   = 4'h1,    // arbitrary value
	parameter [15:0] PART = 16'h1234, // arbitrary value
	parameter [10:0] VEND = 11'h055  // arbitrary value
) (
	input  wire             CLK_I,
	input  wire             RST_I,
	input  wire             TCK_I,
	input  wire             TMS_I,
	input  wire             TDI_I,
	input  wire             TRST_N_I,
	input  wire [BSC_N-1:0] CORE_OUT_I,
	input  wire [BSC_N-1:0] PIN_IN_I,
	output reg              TDO_O,
	output reg              TDO_OE_N_O,
	output wire [BSC_N-1:0] PIN_OUT_O,
	output wire             PIN_OE_N_O
);
	// controller states, one-hot; one flop per state keeps the decode shallow
	localparam [15:0] RESET_ST = 16'h0001; // test logic reset, instruction forced to id
	localparam [15:0] IDLE     = 16'h0002;
	localparam [15:0] SEL_DR   = 16'h0004;
	localparam [15:0] CAP_DR   = 16'h0008;
	localparam [15:0] SH_DR    = 16'h0010;
	localparam [15:0] EX1_DR   = 16'h0020;
	localparam [15:0] PA_DR    = 16'h0040;
	localparam [15:0] EX2_DR   = 16'h0080;
	localparam [15:0] UP_DR    = 16'h0100;
	localparam [15:0] SEL_IR   = 16'h0200;
	localparam [15:0] CAP_IR   = 16'h0400;
	localparam [15:0] SH_IR    = 16'h0800;
	localparam [15:0] EX1_IR   = 16'h1000;
	localparam [15:0] PA_IR    = 16'h2000;
	localparam [15:0] EX2_IR   = 16'h4000;
	localparam [15:0] UP_IR    = 16'h8000;

	// identification word built field by field at fixed bit positions
	wire [`BSTP_ID_W-1:0] id_value;
	assign id_value[`BSTP_REV_HI:`BSTP_REV_LO]   = REV;
	assign id_value[`BSTP_PART_HI:`BSTP_PART_LO] = PART;
	assign id_value[`BSTP_VEND_HI:`BSTP_VEND_LO] = VEND;
	assign id_value[0]                           = 1'b1; // marks an id register present

	// two-flop synchronisers; only stage two is read by logic
	// tms resets to its idle level; trst reads asserted until the pin is seen high
	reg [1:0] tck_s, tms_s, tdi_s, trst_s;
	reg       tck_d;
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tck_s  <= 2'h0;
			tms_s  <= 2'h3;
			tdi_s  <= 2'h0;
			trst_s <= 2'h0;
			tck_d  <= 1'b0;
		end else begin
			tck_s  <= {tck_s[0], TCK_I};
			tms_s  <= {tms_s[0], TMS_I};
			tdi_s  <= {tdi_s[0], TDI_I};
			trst_s <= {trst_s[0], TRST_N_I};
			tck_d  <= tck_s[1];
		end
	end
	wire tck_rise = tck_s[1] & ~tck_d;
	wire tck_fall = ~tck_s[1] & tck_d;
	wire trst     = ~trst_s[1];
	wire tms      = tms_s[1];
	wire tdi      = tdi_s[1];

	// sixteen-state controller stepped on rising tck
	reg [15:0] state;
	reg [15:0] next_state;
	always @* begin
		next_state = state;
		case (state)
		RESET_ST: next_state = tms ? RESET_ST : IDLE;
		IDLE:     next_state = tms ? SEL_DR : IDLE;
		SEL_DR:   next_state = tms ? SEL_IR : CAP_DR;
		CAP_DR:   next_state = tms ? EX1_DR : SH_DR;
		SH_DR:    next_state = tms ? EX1_DR : SH_DR;
		EX1_DR:   next_state = tms ? UP_DR : PA_DR;
		PA_DR:    next_state = tms ? EX2_DR : PA_DR;
		EX2_DR:   next_state = tms ? UP_DR : SH_DR;
		UP_DR:    next_state = tms ? SEL_DR : IDLE;
		SEL_IR:   next_state = tms ? RESET_ST : CAP_IR;
		CAP_IR:   next_state = tms ? EX1_IR : SH_IR;
		SH_IR:    next_state = tms ? EX1_IR : SH_IR;
		EX1_IR:   next_state = tms ? UP_IR : PA_IR;
		PA_IR:    next_state = tms ? EX2_IR : PA_IR;
		EX2_IR:   next_state = tms ? UP_IR : SH_IR;
		UP_IR:    next_state = tms ? SEL_DR : IDLE;
		default:  next_state = RESET_ST;
		endcase
	end
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state <= RESET_ST;
		end else if (trst) begin
			state <= RESET_ST;
		end else if (tck_rise) begin
			state <= next_state;
		end
	end

	// action strobes: the state is acted on at the tck edge that leaves it
	// each strobe lasts one CLK_I cycle, starting two CLK_I edges after the pin edge
	wire do_cap_dr = tck_rise & (state == CAP_DR);
	wire do_sh_dr  = tck_rise & (state == SH_DR);
	wire do_up_dr  = tck_rise & (state == UP_DR);
	wire do_cap_ir = tck_rise & (state == CAP_IR);
	wire do_sh_ir  = tck_rise & (state == SH_IR);
	wire do_up_ir  = tck_rise & (state == UP_IR);

	// instruction register: shift stage and active copy
	reg [`BSTP_IR_W-1:0] ir_shift;
	reg [`BSTP_IR_W-1:0] instruction_reg;
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ir_shift        <= `BSTP_OP_IDCODE;
			instruction_reg <= `BSTP_OP_IDCODE;
		end else if (trst || (state == RESET_ST)) begin
			ir_shift        <= `BSTP_OP_IDCODE;
			instruction_reg <= `BSTP_OP_IDCODE;
		end else if (do_cap_ir) begin
			ir_shift <= 4'h1; // fixed capture pattern, low bits 01
		end else if (do_sh_ir) begin
			ir_shift <= {tdi, ir_shift[`BSTP_IR_W-1:1]};
		end else if (do_up_ir) begin
			instruction_reg <= ir_shift; // undefined codes are never sent
		end
	end

	// decode of five of the six codes; bypass is not decoded
	// reserved codes match none of these and fall to the passthrough bit
	wire op_ext  = (instruction_reg == `BSTP_OP_EXTEST);
	wire op_smp  = (instruction_reg == `BSTP_OP_SAMPLE);
	wire op_id   = (instruction_reg == `BSTP_OP_IDCODE);
	wire op_clmp = (instruction_reg == `BSTP_OP_CLAMP);
	wire op_hz   = (instruction_reg == `BSTP_OP_HIGHZ);
	wire use_bsc = op_ext | op_smp;

	// identification register loaded on capture, shifted lsb first
	reg [`BSTP_ID_W-1:0] identification_reg;
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			identification_reg <= {`BSTP_ID_W{1'b0}};
		end else if (op_id && do_cap_dr) begin
			identification_reg <= id_value;
		end else if (op_id && do_sh_dr) begin
			identification_reg <= {tdi, identification_reg[`BSTP_ID_W-1:1]};
		end
	end

	// one-bit passthrough captures zero, used by bypass, highz, clamp and reserved
	reg single_bit_passthrough_reg;
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			single_bit_passthrough_reg <= 1'b0;
		end else if (do_cap_dr) begin
			single_bit_passthrough_reg <= 1'b0;
		end else if (do_sh_dr) begin
			single_bit_passthrough_reg <= tdi;
		end
	end

	// boundary chain captures pin values only; shifts only when selected
	wire             bsc_so;
	wire [BSC_N-1:0] bsc_cells;
	bstp_chain #(.N(BSC_N)) boundary_cell_chain (
		.clk_i     (CLK_I),
		.rst_i     (RST_I),
		.capture_i (use_bsc & do_cap_dr),
		.shift_i   (use_bsc & do_sh_dr),
		.update_i  (use_bsc & do_up_dr),
		.si_i      (tdi),
		.pins_i    (PIN_IN_I),
		.so_o      (bsc_so),
		.cells_o   (bsc_cells)
	);

	// output pins: cells drive in extest and clamp, all float in highz
	// sample leaves the core in charge so a capture never disturbs the system
	wire drive_cells = op_ext | op_clmp;
	genvar gi;
	generate
		for (gi = 0; gi < BSC_N; gi = gi + 1) begin : g_pin
			assign PIN_OUT_O[gi] = drive_cells ? bsc_cells[gi] : CORE_OUT_I[gi];
		end
	endgenerate
	assign PIN_OE_N_O = op_hz;

	// serial path select; bypass for highz, clamp, bypass and reserved
	// in shift-ir the capture pattern leaves first, whatever instruction is active
	reg tdo_sel;
	always @* begin
		if (state == SH_IR) begin
			tdo_sel = ir_shift[0];
		end else if (use_bsc) begin
			tdo_sel = bsc_so;
		end else if (op_id) begin
			tdo_sel = identification_reg[0];
		end else begin
			tdo_sel = single_bit_passthrough_reg;
		end
	end
	// tdo changes on falling tck, driven only while shifting
	// updating on the fall gives the controller half a tck period of settle time
	always @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			TDO_O      <= 1'b0;
			TDO_OE_N_O <= 1'b1;
		end else if (tck_fall) begin
			TDO_O      <= tdo_sel;
			TDO_OE_N_O <= ~((state == SH_DR) | (state == SH_IR));
		end
	end
endmodule
`default_nettype wire

// >>> test/bstp_checker.sv
// pin-level checks for the scan test port
// assumes it sees only the top ports; bound in below
`timescale 1ns/100ps
`default_nettype none
module bstp_checker #(
	parameter BSC_N = 8
) (
	input wire logic             CLK_I,
	input wire logic             RST_I,
	input wire logic             TCK_I,
	input wire logic             TMS_I,
	input wire logic             TDI_I,
	input wire logic             TRST_N_I,
	input wire logic [BSC_N-1:0] CORE_OUT_I,
	input wire logic [BSC_N-1:0] PIN_IN_I,
	input wire logic             TDO_O,
	input wire logic             TDO_OE_N_O,
	input wire logic [BSC_N-1:0] PIN_OUT_O,
	input wire logic             PIN_OE_N_O
);
	logic       tck_q;
	logic [3:0] age;
	// cycles since a tck edge or test reset; outputs may only move shortly after one
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			tck_q <= 1'b0;
			age   <= 4'h0;
		end else begin
			tck_q <= TCK_I;
			if (TCK_I != tck_q || !TRST_N_I)
				age <= 4'h0;
			else if (age != 4'hf)
				age <= age + 4'h1;
		end
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (RST_I);
	a_reset_tdo_idle: assert property ($fell(RST_I) |-> TDO_OE_N_O && !TDO_O)
		else $error("tdo not idle");
	a_trst_idcode: assert property (!TRST_N_I [*6] |=> !PIN_OE_N_O)
		else $error("trst left float");
	a_float_core: assert property (PIN_OE_N_O |-> PIN_OUT_O == CORE_OUT_I)
		else $error("float pins wrong");
	a_tdo_moves_tck: assert property ($changed(TDO_O) |-> age <= 4'h6)
		else $error("tdo moved alone");
	a_oe_moves_tck: assert property ($changed(TDO_OE_N_O) |-> age <= 4'h6)
		else $error("oe moved alone");
	a_pin_oe_tck: assert property ($changed(PIN_OE_N_O) |-> age <= 4'h6)
		else $error("pin oe moved alone");
	a_oe_stands: assert property (disable iff (RST_I || !TRST_N_I)
		$fell(TDO_OE_N_O) |=> !TDO_OE_N_O [*4])
		else $error("oe too short");
	a_tdo_stands: assert property (disable iff (RST_I || !TRST_N_I)
		$changed(TDO_O) |=> $stable(TDO_O) [*4])
		else $error("tdo too short");
	c_shift: cover property ($fell(TDO_OE_N_O));
	c_float: cover property ($rose(PIN_OE_N_O));
	c_trst: cover property ($fell(TRST_N_I));
endmodule
bind bstp_top bstp_checker #(.BSC_N(BSC_N)) bstp_checker_inst (.CLK_I(CLK_I), .RST_I(RST_I),
	.TCK_I(TCK_I), .TMS_I(TMS_I), .TDI_I(TDI_I), .TRST_N_I(TRST_N_I),
	.CORE_OUT_I(CORE_OUT_I), .PIN_IN_I(PIN_IN_I), .TDO_O(TDO_O), .TDO_OE_N_O(TDO_OE_N_O),
	.PIN_OUT_O(PIN_OUT_O), .PIN_OE_N_O(PIN_OE_N_O));
`default_nettype wire

// >>> test/bstp_ctrl_model.sv
// external scan controller: drives tck, tms, tdi and reads tdo
// assumes clk_i is the bench clock; tck stands still between frames
`timescale 1ns/100ps
`default_nettype none
module bstp_ctrl_model (
	input  wire logic clk_i,
	input  wire logic tdo_i,
	output var  logic tck_o,
	output var  logic tms_o,
	output var  logic tdi_o
);
	// pulled-up rest levels, clock parked low
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b1;
	end
	// one 800 ns tck period; tdo read just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo);
		@(negedge clk_i);
		tck_o = 1'b0;
		tms_o = tms;
		tdi_o = tdi;
		repeat (4) @(negedge clk_i);
		tdo = tdo_i;
		tck_o = 1'b1;
		repeat (3) @(negedge clk_i);
	endtask
	// five ones reach reset, a zero parks in idle
	task automatic to_idle();
		logic t;
		repeat (5) step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask
	// idle, capture, n shifts lsb first, update, idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
			output logic [31:0] dout);
		logic t;
		dout = '0;
		step(1'b1, 1'b1, t);
		if (ir)
			step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
		step(1'b0, 1'b1, t);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], t);
			dout[i] = t;
		end
		step(1'b1, 1'b1, t);
		step(1'b0, 1'b1, t);
	endtask
endmodule
`default_nettype wire

// >>> test/bstp_top_tb.sv
// self-checking bench for the scan test port
// assumes the controller model drives the scan pins
`timescale 1ns/100ps
`default_nettype none
`include "bstp_defines.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] %s exp %h got %h", nm, (e), (g)); end end
module bstp_top_tb;
	localparam [31:0] ID_EXP = {4'h1, 16'h1234, 11'h055, 1'b1}; // arbitrary id fields
	logic        clk, rst, trst_n, tdo_last, b;
	logic [7:0]  core_out, pin_in;
	logic [31:0] d;
	wire         tck, tms, tdi, tdo, tdo_oe_n, pin_oe_n, tdo_line;
	wire  [7:0]  pin_out;
	int          err_count, num_checks, cycles;
	bstp_top #(.BSC_N(8), .REV(4'h1), .PART(16'h1234), .VEND(11'h055)) bstp_top_inst (
		.CLK_I(clk), .RST_I(rst), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TRST_N_I(trst_n),
		.CORE_OUT_I(core_out), .PIN_IN_I(pin_in), .TDO_O(tdo), .TDO_OE_N_O(tdo_oe_n),
		.PIN_OUT_O(pin_out), .PIN_OE_N_O(pin_oe_n));
	bstp_ctrl_model ctl (.clk_i(clk), .tdo_i(tdo_line), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
	// released tdo shows the inverse of its last bit, never a stale copy
	always @(posedge clk)
		if (rst)
			tdo_last <= 1'b0;
		else if (!tdo_oe_n)
			tdo_last <= tdo;
	assign tdo_line = tdo_oe_n ? ~tdo_last : tdo;
	// clock and hang guard
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic t_idcode();
		ctl.to_idle();
		ctl.scan(1'b0, 32, 32'h0, d);
		`CHK("id", ID_EXP, d)
		`CHK("tdo released", 1'b1, tdo_oe_n)
		ctl.scan(1'b1, 4, `BSTP_OP_HIGHZ, d);
		@(negedge clk);
		trst_n = 1'b0;
		repeat (6) @(negedge clk);
		trst_n = 1'b1;
		ctl.step(1'b0, 1'b1, b);
		ctl.scan(1'b0, 32, 32'hffffffff, d);
		`CHK("id after trst", ID_EXP, d)
		$display("test idcode done");
	endtask
	task automatic t_sample_extest();
		ctl.scan(1'b1, 4, `BSTP_OP_SAMPLE, d);
		ctl.scan(1'b0, 8, 32'h3c, d);
		`CHK("sampled", pin_in, d[7:0])
		`CHK("sample pins", core_out, pin_out)
		ctl.scan(1'b1, 4, `BSTP_OP_EXTEST, d);
		`CHK("extest pins", 8'h3c, pin_out)
		`CHK("extest oe", 1'b0, pin_oe_n)
		$display("test sample extest done");
	endtask
	task automatic t_passthrough();
		logic [3:0] codes [4] = '{`BSTP_OP_CLAMP, `BSTP_OP_HIGHZ, `BSTP_OP_BYPASS, `BSTP_OP_CLAMP};
		for (int k = 0; k < 4; k++) begin
			ctl.scan(1'b1, 4, codes[k], d); // only defined codes are issued
			`CHK("pin oe", (k == 1), pin_oe_n)
			`CHK("pins", ((k == 0) || (k == 3)) ? 8'h3c : core_out, pin_out)
			ctl.scan(1'b0, 8, 32'hb4, d);
			`CHK("one bit path", 8'h68, d[7:0])
		end
		$display("test passthrough done");
	endtask
	initial begin
		rst = 1'b1;
		trst_n = 1'b1;
		core_out = 8'h96;
		pin_in = 8'ha5;
		repeat (5) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		t_idcode();
		t_sample_extest();
		t_passthrough();
		complete_run();
	end
endmodule
`default_nettype wire
